// file: rtl/urw_pkg.sv
package urw_pkg;

   // clock rate
   localparam int CLK_MHZ = 250;

   // register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h08;
   localparam logic [5:0] OFS_EN_SET = 6'h10;
   localparam logic [5:0] OFS_EN_CLR = 6'h14;
   localparam logic [5:0] OFS_FLAGS  = 6'h18;
   localparam logic [5:0] OFS_STATUS = 6'h1c;

   // interrupt flag and enable bit positions
   localparam int IRQ_BUS_IDLE       = 0;
   localparam int IRQ_FRAME_START    = 2;
   localparam int IRQ_RESET_DONE     = 3;
   localparam int IRQ_BUS_ACTIVITY   = 4;
   localparam int IRQ_RESUME_DONE    = 5;
   localparam int IRQ_HOST_RESUME    = 6;
   localparam int IRQ_RAM_ACCESS     = 7;
   localparam int IRQ_LINK_PM_NOTYET = 8;
   localparam int IRQ_LINK_PM_SLEEP  = 9;
   localparam logic [15:0] IRQ_USED  = 16'h03fd;

   // control register field
   localparam int CTRL_SEND_RESUME = 1;

   // reset values
   localparam logic [15:0] EN_RESET    = 16'h0000;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;

   // synchronised pin indices
   localparam int SYN_IDLE       = 0;
   localparam int SYN_HOST_K     = 1;
   localparam int SYN_FRAME      = 2;
   localparam int SYN_RESET_DONE = 3;
   localparam int SYN_RAM_ERR    = 4;
   localparam int SYN_LPM_NOTYET = 5;
   localparam int SYN_LPM_SLEEP  = 6;
   localparam int SYN_W          = 7;

   // timing, microseconds, and derived cycle counts
   localparam int SUSPEND_DETECT_US  = 3000;
   localparam int INACTIVITY_WAKE_US = 5000;
   localparam int RESUME_DRIVE_US    = 2000;
   localparam int SUSPEND_CYCLES     = SUSPEND_DETECT_US * CLK_MHZ;
   localparam int INACTIVITY_CYCLES  = INACTIVITY_WAKE_US * CLK_MHZ;
   localparam int RESUME_CYCLES      = RESUME_DRIVE_US * CLK_MHZ;
   localparam int TMR_W              = 24;

   // link power state, gray along active-suspended-resuming-host resume
   typedef enum logic [1:0] {
      ST_ACTIVE    = 2'b00,
      ST_SUSPENDED = 2'b01,
      ST_RESUMING  = 2'b11,
      ST_HOST_RSM  = 2'b10
   } urw_state_e;

endpackage

// file: rtl/urw_sync.sv
`timescale 1ns/100ps
module urw_sync
   import urw_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [SYN_W-1:0] async_in,
   output logic      [SYN_W-1:0] sync_out
);

   logic [SYN_W-1:0] meta;

   // two flops per pin, first stage read only by the second
   for (genvar i = 0; i < SYN_W; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta[i]     <= 1'b0;
            sync_out[i] <= 1'b0;
         end
         else
         begin
            meta[i]     <= async_in[i];
            sync_out[i] <= meta[i];
         end
      end
   end

endmodule

// file: rtl/urw_timer.sv
`timescale 1ns/100ps
module urw_timer
   import urw_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             run,
   input  wire logic [TMR_W-1:0] limit,
   output logic                  done
);

   logic [TMR_W-1:0] cnt;

   // counts while run holds, one pulse after limit cycles, restarts when run drops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt  <= '0;
         done <= 1'b0;
      end
      else if (!run)
      begin
         cnt  <= '0;
         done <= 1'b0;
      end
      else
      begin
         done <= (cnt == limit - 24'h1);
         if (cnt != limit)
            cnt <= cnt + 24'h1;
      end
   end

endmodule

// file: rtl/urw_top.sv
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module urw_top
   import urw_pkg::*;
#(
   parameter int SUSPEND_CNT    = SUSPEND_CYCLES,
   parameter int INACTIVITY_CNT = INACTIVITY_CYCLES,
   parameter int RESUME_CNT     = RESUME_CYCLES
)
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        line_idle,
   input  wire logic        line_host_k,
   input  wire logic        frame_start_in,
   input  wire logic        reset_done_in,
   input  wire logic        ram_access_err_in,
   input  wire logic        link_pm_notyet_in,
   input  wire logic        link_pm_sleep_in,
   output logic             resume_drive,
   output logic             pad_active,
   output logic             irq
);

   logic             rst_meta;
   logic             rst_n;
   logic [SYN_W-1:0] pin_sync;
   logic [SYN_W-1:0] pin_prev;
   logic [SYN_W-1:0] pin_rise;
   logic             idle_s;
   logic             host_k_s;
   urw_state_e       state;
   urw_state_e       next_state;
   logic [15:0]      en;
   logic [15:0]      flags;
   logic             send_host_resume;
   logic             susp_done;
   logic             inact_done;
   logic             drive_done;
   logic             wr_take;
   logic [15:0]      wbits;
   logic             wr_ctrl;
   logic             wr_en_set;
   logic             wr_en_clr;
   logic             wr_flags;
   logic             sw_resume_req;
   logic             resume_start;
   logic [15:0]      hw_set;
   logic [15:0]      hw_clr;
   logic [31:0]      read_value;

   // reset release through two flops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // pin synchronisers
   urw_sync u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({link_pm_sleep_in, link_pm_notyet_in, ram_access_err_in, reset_done_in,
                  frame_start_in, line_host_k, line_idle}),
      .sync_out (pin_sync)
   );

   // edge memory for pin events
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_prev <= '0;
      else
         pin_prev <= pin_sync;
   end

   assign pin_rise = pin_sync & ~pin_prev;
   assign idle_s   = pin_sync[SYN_IDLE];
   assign host_k_s = pin_sync[SYN_HOST_K];

   // idle-bus and resume-length timers
   urw_timer u_susp_tmr (
      .clk   (clk),
      .rst_n (rst_n),
      .run   ((state == ST_ACTIVE) && idle_s),
      .limit (SUSPEND_CNT[TMR_W-1:0]),
      .done  (susp_done)
   );

   urw_timer u_inact_tmr (
      .clk   (clk),
      .rst_n (rst_n),
      .run   ((state == ST_SUSPENDED) && idle_s),
      .limit (INACTIVITY_CNT[TMR_W-1:0]),
      .done  (inact_done)
   );

   urw_timer u_drive_tmr (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (state == ST_RESUMING),
      .limit (RESUME_CNT[TMR_W-1:0]),
      .done  (drive_done)
   );

   // bus write decode, byte lanes 0 and 1 only
   assign wr_take   = avs_write && !avs_waitrequest;
   assign wbits     = avs_writedata[15:0] & {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wr_ctrl   = wr_take && (avs_address == OFS_CTRL);
   assign wr_en_set = wr_take && (avs_address == OFS_EN_SET);
   assign wr_en_clr = wr_take && (avs_address == OFS_EN_CLR);
   assign wr_flags  = wr_take && (avs_address == OFS_FLAGS);

   // resume start only from suspend with its flag up
   assign sw_resume_req = wr_ctrl && wbits[CTRL_SEND_RESUME];
   assign resume_start  = (state == ST_SUSPENDED) && flags[IRQ_BUS_IDLE]
                          && (sw_resume_req || inact_done);

   // link state sequencing and hardware flag events
   always_comb
   begin
      next_state = state;
      hw_set     = 16'h0000;
      hw_clr     = 16'h0000;
      hw_set[IRQ_FRAME_START]    = pin_rise[SYN_FRAME];
      hw_set[IRQ_RESET_DONE]     = pin_rise[SYN_RESET_DONE];
      hw_set[IRQ_RAM_ACCESS]     = pin_rise[SYN_RAM_ERR];
      hw_set[IRQ_LINK_PM_NOTYET] = pin_rise[SYN_LPM_NOTYET];
      hw_set[IRQ_LINK_PM_SLEEP]  = pin_rise[SYN_LPM_SLEEP];
      case (state)
         ST_ACTIVE:
         begin
            if (susp_done)
            begin
               next_state           = ST_SUSPENDED;
               hw_set[IRQ_BUS_IDLE] = 1'b1;
            end
         end
         ST_SUSPENDED:
         begin
            if (resume_start)
            begin
               next_state               = ST_RESUMING;
               hw_set[IRQ_BUS_ACTIVITY] = 1'b1;
               hw_clr[IRQ_BUS_IDLE]     = 1'b1;
            end
            else if (!idle_s)
            begin
               hw_set[IRQ_BUS_ACTIVITY] = 1'b1;
               next_state = host_k_s ? ST_HOST_RSM : ST_ACTIVE;
            end
         end
         ST_RESUMING:
         begin
            if (drive_done)
            begin
               next_state              = ST_HOST_RSM;
               hw_set[IRQ_HOST_RESUME] = 1'b1;
            end
         end
         ST_HOST_RSM:
         begin
            if (!host_k_s)
            begin
               next_state              = ST_ACTIVE;
               hw_set[IRQ_RESUME_DONE] = 1'b1;
            end
         end
         default:
            next_state = ST_ACTIVE;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= ST_ACTIVE;
      else
         state <= next_state;
   end

   // upstream k drive and pad activity
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         resume_drive <= 1'b0;
         pad_active   <= 1'b1;
      end
      else
      begin
         resume_drive <= (next_state == ST_RESUMING);
         pad_active   <= (next_state != ST_SUSPENDED);
      end
   end

   // send-resume control bit, set on start, cleared when drive ends
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         send_host_resume <= 1'b0;
      else if (resume_start)
         send_host_resume <= 1'b1;
      else if (drive_done)
         send_host_resume <= 1'b0;
   end

   // shared enable bits, both views act on one register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         en <= EN_RESET;
      else if (wr_en_set)
         en <= en | (wbits & IRQ_USED);
      else if (wr_en_clr)
         en <= en & ~(wbits & IRQ_USED);
   end

   // sticky flags, write one clears, hardware set wins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         flags <= FLAGS_RESET;
      else
         flags <= ((flags & ~(wr_flags ? wbits : 16'h0000) & ~hw_clr) | hw_set) & IRQ_USED;
   end

   // level interrupt from enabled flags
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= |(flags & en);
   end

   // read mux
   always_comb
   begin
      read_value = 32'h0000_0000;
      case (avs_address)
         OFS_CTRL:   read_value[CTRL_SEND_RESUME] = send_host_resume;
         OFS_EN_SET: read_value[15:0] = en;
         OFS_EN_CLR: read_value[15:0] = en;
         OFS_FLAGS:  read_value[15:0] = flags;
         OFS_STATUS: read_value[3:0]  = {pad_active, resume_drive, state};
         default:    read_value = 32'h0000_0000;
      endcase
   end

   // one wait cycle, then answer
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   // read data latched in the wait cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= read_value;
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_only_resume_out: assert property (resume_drive |-> state == ST_RESUMING)
      else $error("resume driven outside resuming state");
   a_refuse_no_suspend: assert property ($rose(resume_drive) |-> $past(flags[IRQ_BUS_IDLE]))
      else $error("resume started without suspend flag");
   a_sw_start_drive: assert property (sw_resume_req && state == ST_SUSPENDED && flags[IRQ_BUS_IDLE]
      |=> resume_drive && send_host_resume)
      else $error("software resume request not driven");
   a_auto_wake_start: assert property (inact_done && state == ST_SUSPENDED && flags[IRQ_BUS_IDLE]
      |=> resume_drive)
      else $error("inactivity did not start resume");
   a_wake_flag_swap: assert property ($rose(resume_drive) |-> flags[IRQ_BUS_ACTIVITY]
      && !flags[IRQ_BUS_IDLE])
      else $error("flags not swapped at resume start");
   a_ctrl_auto_clear: assert property ($fell(resume_drive) |-> !send_host_resume)
      else $error("send resume bit still set after drive");
   a_resume_done_flag: assert property (state == ST_HOST_RSM && !host_k_s |=> flags[IRQ_RESUME_DONE])
      else $error("resume done flag not set");
   a_clear_view_read: assert property (avs_read && avs_waitrequest && avs_address == OFS_EN_CLR
      |=> avs_readdata[15:0] == $past(en))
      else $error("enable clear read mismatch");
   a_clear_bits_only: assert property (wr_en_clr |=> en == ($past(en) & ~($past(wbits) & IRQ_USED)))
      else $error("enable clear write wrong");
   a_unused_bits_zero: assert property ((en & ~IRQ_USED) == 16'h0000 && (flags & ~IRQ_USED) == 16'h0000)
      else $error("unused enable bit set");
   a_irq_follows: assert property (##1 irq == $past(|(flags & en)))
      else $error("interrupt level wrong");
   a_pad_idle_sus: assert property ($rose(flags[IRQ_BUS_IDLE]) && state == ST_SUSPENDED |-> !pad_active)
      else $error("pad active in suspend");

   c_sw_resume: cover property (sw_resume_req && resume_start);
   c_auto_resume: cover property (inact_done && resume_start);
   c_host_rebroadcast: cover property (state == ST_HOST_RSM ##1 state == ST_ACTIVE);
   c_irq_rise: cover property ($rose(irq));
   c_host_wake: cover property (state == ST_SUSPENDED ##1 state == ST_HOST_RSM);

endmodule

// file: tb/urw_host_model.sv
`timescale 1ns/100ps
module urw_host_model
   import urw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       resume_drive,
   input  wire logic       suspend_req,
   input  wire logic       host_wake,
   input  wire logic [7:0] k_len,
   output logic            line_idle,
   output logic            line_host_k
);
   logic [7:0] k_cnt;
   logic       woke;

   // host echoes the device resume with its own K, held k_len + 1 cycles after the device stops
   // a host_wake pulse starts a host resume of its own from suspend
   // remote wakeup is taken as already enabled by the host, no setup traffic modelled
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         line_host_k <= 1'b0;
         k_cnt       <= 8'h00;
      end
      else if (resume_drive || host_wake)
      begin
         line_host_k <= 1'b1;
         k_cnt       <= k_len;
      end
      else if (k_cnt != 8'h00)
         k_cnt <= k_cnt - 8'h01;
      else
         line_host_k <= 1'b0;
   end

   // after a wakeup the host keeps the bus busy until told to idle again
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         woke <= 1'b0;
      else if (!suspend_req)
         woke <= 1'b0;
      else if (resume_drive || host_wake)
         woke <= 1'b1;
   end

   // idle J only while the host is quiet
   assign line_idle = suspend_req & ~woke & ~line_host_k;
endmodule

// file: tb/usb_device_resume_irq_enable_tb.sv
`timescale 1ns/100ps
module usb_device_resume_irq_enable_tb
   import urw_pkg::*;
;
   localparam int SUS = 20;
   localparam int INA = 80;
   localparam int RSM = 10;
   logic        clk = 1'b0;
   logic        arst_n;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        line_idle;
   logic        line_host_k;
   logic [4:0]  ev;
   logic        resume_drive;
   logic        pad_active;
   logic        irq;
   logic        suspend_req;
   logic        host_wake;
   logic [7:0]  k_len;
   logic [31:0] rd;
   logic [15:0] en;
   logic [15:0] lfsr = 16'h6c6e;
   int          miscompares = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          drv_cnt = 0;
   int          n;
   int          pos[5] = '{IRQ_FRAME_START, IRQ_RESET_DONE, IRQ_RAM_ACCESS, IRQ_LINK_PM_NOTYET, IRQ_LINK_PM_SLEEP};

   urw_top #(.SUSPEND_CNT(SUS), .INACTIVITY_CNT(INA), .RESUME_CNT(RSM)) dut_u (
      .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_idle(line_idle),
      .line_host_k(line_host_k), .frame_start_in(ev[0]), .reset_done_in(ev[1]),
      .ram_access_err_in(ev[2]), .link_pm_notyet_in(ev[3]), .link_pm_sleep_in(ev[4]),
      .resume_drive(resume_drive), .pad_active(pad_active), .irq(irq));

   urw_host_model host_u (
      .clk(clk), .rst_n(arst_n), .resume_drive(resume_drive), .suspend_req(suspend_req), .host_wake(host_wake),
      .k_len(k_len), .line_idle(line_idle), .line_host_k(line_host_k));

   // clock, watchdog and resume length counter
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      drv_cnt = drv_cnt + (resume_drive === 1'b1 ? 1 : 0);
      if (cyc == 20000)
      begin
         miscompares = miscompares + 1;
         close_out();
      end
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // enables after a write through either view
   function automatic logic [15:0] en_next(input logic [15:0] e, input logic [15:0] w, input logic set);
      return set ? (e | (w & IRQ_USED)) : (e & ~w);
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_address   <= a;
      avs_writedata <= {16'h0000, d};
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0000);
      chk(rd, {16'h0000, exp});
   endtask

   task automatic cycles(input int c);
      repeat (c) @(posedge clk);
   endtask

   // main sequence
   initial
   begin
      arst_n = 1'b0;
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      ev = 5'h00;
      suspend_req = 1'b0;
      host_wake = 1'b0;
      k_len = 8'h04;
      en = EN_RESET;
      cycles(12);
      arst_n <= 1'b1;
      cycles(4);
      chk(irq, 1'b0);
      rchk(OFS_EN_CLR, EN_RESET);
      rchk(OFS_FLAGS, FLAGS_RESET);
      rchk(6'h20, 16'h0000);
      // random enable traffic through both views
      for (int i = 0; i < 8; i++)
      begin
         lfsr = lfsr_next(lfsr);
         bus(1'b1, OFS_EN_SET, lfsr);
         en = en_next(en, lfsr, 1'b1);
         rchk(OFS_EN_CLR, en);
         lfsr = lfsr_next(lfsr);
         bus(1'b1, OFS_EN_CLR, lfsr);
         en = en_next(en, lfsr, 1'b0);
         rchk(OFS_EN_SET, en);
      end
      bus(1'b1, OFS_EN_SET, 16'hffff);
      rchk(OFS_EN_CLR, IRQ_USED);
      bus(1'b1, OFS_EN_CLR, 16'h0000);
      rchk(OFS_EN_CLR, IRQ_USED);
      avs_byteenable <= 4'h1;
      bus(1'b1, OFS_EN_CLR, 16'hffff);
      rchk(OFS_EN_CLR, 16'h0300);
      avs_byteenable <= 4'hf;
      bus(1'b1, OFS_EN_CLR, 16'h0300);
      rchk(OFS_EN_SET, 16'h0000);
      // each event raises its flag, irq follows its enable
      for (int k = 0; k < 5; k++)
      begin
         bus(1'b1, OFS_FLAGS, 16'h03ff);
         bus(1'b1, OFS_EN_SET, 16'h0001 << pos[k]);
         ev[k] <= 1'b1;
         cycles(8);
         chk(irq, 1'b1);
         rchk(OFS_FLAGS, 16'h0001 << pos[k]);
         bus(1'b1, OFS_EN_CLR, 16'h0001 << pos[k]);
         ev[k] <= 1'b0;
         cycles(3);
         chk(irq, 1'b0);
      end
      // resume refused while the bus is active
      bus(1'b1, OFS_CTRL, 16'h0002);
      cycles(3);
      chk(resume_drive, 1'b0);
      rchk(OFS_CTRL, 16'h0000);
      // suspend, then software resume answered by a host rebroadcast
      bus(1'b1, OFS_FLAGS, 16'h03ff);
      k_len <= 8'h04 + {4'h0, lfsr[3:0]};
      suspend_req <= 1'b1;
      while (pad_active !== 1'b0)
         @(posedge clk);
      rchk(OFS_FLAGS, 16'h0001);
      n = drv_cnt;
      bus(1'b1, OFS_CTRL, 16'h0002);
      cycles(2);
      chk(resume_drive, 1'b1);
      rchk(OFS_CTRL, 16'h0002);
      while (resume_drive !== 1'b0)
         @(posedge clk);
      chk(drv_cnt - n >= RSM && drv_cnt - n <= RSM + 1, 1'b1);
      rchk(OFS_CTRL, 16'h0000);
      while (line_host_k !== 1'b0)
         @(posedge clk);
      cycles(6);
      rchk(OFS_FLAGS, 16'h0070);
      rchk(OFS_STATUS, 16'h0008);
      // suspend with the idle flag cleared refuses resume, host activity wakes
      bus(1'b1, OFS_FLAGS, 16'h03ff);
      suspend_req <= 1'b0;
      cycles(4);
      suspend_req <= 1'b1;
      while (pad_active !== 1'b0)
         @(posedge clk);
      bus(1'b1, OFS_FLAGS, 16'h0001);
      bus(1'b1, OFS_CTRL, 16'h0002);
      cycles(2);
      chk(resume_drive, 1'b0);
      suspend_req <= 1'b0;
      cycles(6);
      chk(pad_active, 1'b1);
      rchk(OFS_FLAGS, 16'h0010);
      // host resume from suspend, the device stays quiet
      bus(1'b1, OFS_FLAGS, 16'h03ff);
      suspend_req <= 1'b1;
      while (pad_active !== 1'b0)
         @(posedge clk);
      n = drv_cnt;
      host_wake <= 1'b1;
      @(posedge clk);
      host_wake <= 1'b0;
      cycles(2);
      while (line_host_k !== 1'b0)
         @(posedge clk);
      cycles(6);
      rchk(OFS_FLAGS, 16'h0031);
      rchk(OFS_STATUS, 16'h0008);
      chk(drv_cnt - n, 32'h0000_0000);
      suspend_req <= 1'b0;
      cycles(2);
      // inactivity in suspend starts resume without software
      suspend_req <= 1'b1;
      while (pad_active !== 1'b0)
         @(posedge clk);
      n = 0;
      while (resume_drive !== 1'b1)
      begin
         @(posedge clk);
         n = n + 1;
      end
      chk(n >= INA - 4 && n <= INA + 4, 1'b1);
      while (resume_drive !== 1'b0)
         @(posedge clk);
      cycles(4);
      close_out();
   end
endmodule
